// >>> rtl/pes_framer_pkg.sv
// Shared constants and carrier types for the serial stream PES framer.
package pes_framer_pkg;
   localparam int unsigned TS_LEN = 188;
   localparam logic [7:0] TS_LAST = 8'h00_BB;
   localparam logic [7:0] SYNC_BYTE = 8'h00_47;
   localparam logic [2:0] TS_HDR_TOP = 3'h2;
   localparam logic [3:0] TS_AFC_PAYLOAD = 4'h1;
   localparam logic [7:0] PFX_ZERO = 8'h00_00;
   localparam logic [7:0] PFX_ONE = 8'h00_01;
   localparam logic [7:0] PRIVATE_STREAM_ID = 8'h00_BD;
   // Bytes after the length field: the whole rest of one transport packet.
   localparam logic [15:0] PES_LEN = 16'h00_B2;
   localparam logic [7:0] PES_FLAGS1 = 8'h00_80;
   localparam logic [7:0] PES_FLAGS2_EXT = 8'h00_01;
   localparam logic [7:0] PES_HDR_DATA_LEN = 8'h00_01;
   localparam logic [7:0] PES_EXT_BYTE = 8'h00_0E;
   localparam logic [7:0] SYNC_DATA_ID = 8'h00_21;
   localparam logic [1:0] DP_RESERVED = 2'h3;
   localparam logic [3:0] RATE_RESERVED = 4'hF;
   localparam logic [7:0] RATE_BYTES = 8'h00_04;
   // Byte positions inside the transport packet.
   localparam logic [7:0] IX_SYNC = 8'h00_00;
   localparam logic [7:0] IX_PID_HI = 8'h00_01;
   localparam logic [7:0] IX_PID_LO = 8'h00_02;
   localparam logic [7:0] IX_CC = 8'h00_03;
   localparam logic [7:0] IX_PFX0 = 8'h00_04;
   localparam logic [7:0] IX_PFX1 = 8'h00_05;
   localparam logic [7:0] IX_PFX2 = 8'h00_06;
   localparam logic [7:0] IX_SID = 8'h00_07;
   localparam logic [7:0] IX_LEN_HI = 8'h00_08;
   localparam logic [7:0] IX_LEN_LO = 8'h00_09;
   localparam logic [7:0] IX_FLAGS1 = 8'h00_0A;
   localparam logic [7:0] IX_FLAGS2 = 8'h00_0B;
   localparam logic [7:0] IX_HDL = 8'h00_0C;
   localparam logic [7:0] IX_EXT = 8'h00_0D;
   localparam logic [7:0] IX_DATA_ID = 8'h00_0E;
   localparam logic [7:0] IX_SUB_ID = 8'h00_0F;
   localparam logic [7:0] IX_DP_FLAGS = 8'h00_10;
   localparam logic [7:0] IX_OPT = 8'h00_11;
   localparam logic [2:0] BIT_LAST = 3'h7;

   typedef struct packed {
      logic valid;
      logic start;
      logic [7:0] data;
   } ts_beat_t;

   typedef struct packed {
      logic rate_en;
      logic [27:0] rate;
   } rate_cfg_t;

   typedef enum logic {
      ST_HDR = 1'b0,
      ST_PAY = 1'b1
   } frm_state_t;
endpackage

// >>> rtl/ser_byte_rx.sv
// Serial bit stream to byte converter running on the link clock.
`timescale 1ns/10ps
`default_nettype none
module ser_byte_rx
   import pes_framer_pkg::*;
(
   input wire logic ser_clk,
   input wire logic rst,
   input wire logic ser_data,
   output logic [7:0] byte_q,
   output logic tgl_q
);
   logic rst_s1_q;
   logic rst_s2_q;
   logic [6:0] sh_q;
   logic [2:0] bit_q;

   // Reset only takes effect while the link clock runs.
   always_ff @(posedge ser_clk) begin
      rst_s1_q <= rst;
      rst_s2_q <= rst_s1_q;
   end

   always_ff @(posedge ser_clk) begin
      if (rst_s2_q) begin
         sh_q <= '0;
         bit_q <= '0;
         byte_q <= '0;
         tgl_q <= 1'b0;
      end else begin
         sh_q <= {sh_q[5:0], ser_data};
         bit_q <= bit_q + 3'h1;
         if (bit_q == BIT_LAST) begin
            // The byte stays still for eight bit times while the toggle crosses.
            byte_q <= {sh_q, ser_data};
            tgl_q <= ~tgl_q;
         end
      end
   end
endmodule
`default_nettype wire

// >>> rtl/sync_serial_pes_framer.sv
// Wraps a synchronous serial stream into PES packets in transport packets.
//
// Behaviour
// - Serial bytes go into a data packet structure carried in a PES packet mapped into transport packets.
// - Every data packet carries the synchronous data stream identifier byte.
// - Every PES packet has its header extension flag set to one.
// - The output rate flag is one exactly when the output rate field is sent.
// - The data packet header length counts all optional fields and private bytes.
// - Every PES packet carries the private stream id.
// - No PES packet carries a zero length field; the length is always stated.
// - Output is cut into transport packets of exactly 188 bytes.
`timescale 1ns/10ps
`default_nettype none
module sync_serial_pes_framer
   import pes_framer_pkg::*;
#(
   parameter logic [12:0] PID = 13'h0_100,
   parameter logic [7:0] SUB_STREAM_ID = 8'h00_00,
   parameter logic [3:0] PRIV_LEN = 4'h0,
   parameter logic [7:0] PRIV_BYTE = 8'h00_FF
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ser_clk,
   input wire logic ser_data,
   input wire rate_cfg_t rate_cfg,
   output ts_beat_t ts_q
);
   logic [7:0] rx_byte;
   logic rx_tgl;
   logic tgl_s1_q;
   logic tgl_s2_q;
   logic tgl_s3_q;
   logic push;
   logic pop;
   logic [7:0] pend0_q;
   logic [7:0] pend1_q;
   logic [1:0] cnt_q;
   frm_state_t state_q;
   logic [7:0] idx_q;
   logic [3:0] cc_q;
   rate_cfg_t cfg_q;
   logic [3:0] dp_hlen;
   logic [7:0] hdr_end;

   ser_byte_rx u_rx (
      .ser_clk(ser_clk),
      .rst(rst),
      .ser_data(ser_data),
      .byte_q(rx_byte),
      .tgl_q(rx_tgl)
   );

   // Byte data is read only after the toggle is two flops deep, when stable.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tgl_s1_q <= 1'b0;
         tgl_s2_q <= 1'b0;
         tgl_s3_q <= 1'b0;
      end else begin
         tgl_s1_q <= rx_tgl;
         tgl_s2_q <= tgl_s1_q;
         tgl_s3_q <= tgl_s2_q;
      end
   end

   assign push = tgl_s2_q ^ tgl_s3_q;
   assign pop = (state_q == ST_PAY) && (cnt_q != 2'h0);

   // Two slots cover the bytes that arrive while a header goes out.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pend0_q <= '0;
         pend1_q <= '0;
         cnt_q <= '0;
      end else begin
         unique case ({push, pop})
            2'b10: begin
               if (cnt_q == 2'h0) begin
                  pend0_q <= rx_byte;
                  cnt_q <= 2'h1;
               end else if (cnt_q == 2'h1) begin
                  pend1_q <= rx_byte;
                  cnt_q <= 2'h2;
               end
            end
            2'b01: begin
               pend0_q <= pend1_q;
               cnt_q <= cnt_q - 2'h1;
            end
            2'b11: begin
               if (cnt_q == 2'h1) begin
                  pend0_q <= rx_byte;
               end else begin
                  pend0_q <= pend1_q;
                  pend1_q <= rx_byte;
               end
            end
            2'b00: begin
            end
         endcase
      end
   end

   // Optional field bytes: the rate word when present, then private bytes.
   assign dp_hlen = (cfg_q.rate_en ? RATE_BYTES[3:0] : 4'h0) + PRIV_LEN;
   assign hdr_end = IX_OPT + {4'h0, dp_hlen};

   function automatic logic [7:0] hdr_byte(
      input logic [7:0] ix,
      input logic [3:0] cc,
      input rate_cfg_t cfg,
      input logic [3:0] hlen
   );
      logic [7:0] off;
      logic [31:0] rw;
      off = ix - IX_OPT;
      rw = {cfg.rate, RATE_RESERVED};
      unique case (ix)
         IX_SYNC: hdr_byte = SYNC_BYTE;
         IX_PID_HI: hdr_byte = {TS_HDR_TOP, PID[12:8]};
         IX_PID_LO: hdr_byte = PID[7:0];
         IX_CC: hdr_byte = {TS_AFC_PAYLOAD, cc};
         IX_PFX0: hdr_byte = PFX_ZERO;
         IX_PFX1: hdr_byte = PFX_ZERO;
         IX_PFX2: hdr_byte = PFX_ONE;
         IX_SID: hdr_byte = PRIVATE_STREAM_ID;
         IX_LEN_HI: hdr_byte = PES_LEN[15:8];
         IX_LEN_LO: hdr_byte = PES_LEN[7:0];
         IX_FLAGS1: hdr_byte = PES_FLAGS1;
         IX_FLAGS2: hdr_byte = PES_FLAGS2_EXT;
         IX_HDL: hdr_byte = PES_HDR_DATA_LEN;
         IX_EXT: hdr_byte = PES_EXT_BYTE;
         IX_DATA_ID: hdr_byte = SYNC_DATA_ID;
         IX_SUB_ID: hdr_byte = SUB_STREAM_ID;
         IX_DP_FLAGS: hdr_byte = {1'b0, cfg.rate_en, DP_RESERVED, hlen};
         default: begin
            if (cfg.rate_en && (off < RATE_BYTES)) begin
               unique case (off[1:0])
                  2'h0: hdr_byte = rw[31:24];
                  2'h1: hdr_byte = rw[23:16];
                  2'h2: hdr_byte = rw[15:8];
                  2'h3: hdr_byte = rw[7:0];
               endcase
            end else begin
               hdr_byte = PRIV_BYTE;
            end
         end
      endcase
   endfunction

   // Rate settings are held for a whole packet so header fields agree.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cfg_q <= '0;
      end else if (state_q == ST_HDR && idx_q == IX_SYNC) begin
         cfg_q <= rate_cfg;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= ST_HDR;
         idx_q <= '0;
         cc_q <= '0;
         ts_q <= '0;
      end else begin
         ts_q.valid <= 1'b0;
         ts_q.start <= 1'b0;
         unique case (state_q)
            ST_HDR: begin
               ts_q.valid <= 1'b1;
               ts_q.start <= (idx_q == IX_SYNC);
               if (idx_q == IX_SYNC) begin
                  ts_q.data <= hdr_byte(idx_q, cc_q, rate_cfg,
                     (rate_cfg.rate_en ? RATE_BYTES[3:0] : 4'h0) + PRIV_LEN);
               end else begin
                  ts_q.data <= hdr_byte(idx_q, cc_q, cfg_q, dp_hlen);
               end
               idx_q <= idx_q + 8'h01;
               if (idx_q + 8'h01 == hdr_end) begin
                  state_q <= ST_PAY;
               end
            end
            ST_PAY: begin
               if (pop) begin
                  ts_q.valid <= 1'b1;
                  ts_q.data <= pend0_q;
                  if (idx_q == TS_LAST) begin
                     // Packet closes at exactly 188 bytes.
                     idx_q <= '0;
                     cc_q <= cc_q + 4'h1;
                     state_q <= ST_HDR;
                  end else begin
                     idx_q <= idx_q + 8'h01;
                  end
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> tb/framer_assertions.sv
// Checker that watches the framer's transport output.
`timescale 1ns/10ps
`default_nettype none
module framer_assertions
   import pes_framer_pkg::*;
#(
   parameter logic [3:0] PRIV_LEN = 4'h0
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire rate_cfg_t rate_cfg,
   input wire ts_beat_t ts_q
);
   logic [7:0] idx_q;
   logic rate_q;
   wire v = ts_q.valid;
   wire [7:0] d = ts_q.data;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // The index of the beat on ts_q; zero only before the first start.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         idx_q <= 8'h00;
      end else if (v) begin
         idx_q <= ts_q.start ? 8'h01 : idx_q + 8'h01;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rate_q <= 1'b0;
      end else if (v && ts_q.start) begin
         rate_q <= rate_cfg.rate_en;
      end
   end
   property p_sync; v && ts_q.start |-> d == SYNC_BYTE; endproperty
   a_sync: assert property (p_sync) else $error("bad sync byte");
   property p_start;
      v |-> ts_q.start == (idx_q == 8'h00 || idx_q == TS_LAST + 8'h01);
   endproperty
   a_start: assert property (p_start) else $error("bad packet size");
   property p_burst; v && ts_q.start |=> v [*8]; endproperty
   a_burst: assert property (p_burst) else $error("header gap");
   property p_pfx; v && idx_q == IX_PFX2 |-> d == PFX_ONE; endproperty
   a_pfx: assert property (p_pfx) else $error("bad prefix");
   property p_sid; v && idx_q == IX_SID |-> d == PRIVATE_STREAM_ID; endproperty
   a_sid: assert property (p_sid) else $error("bad stream id");
   property p_len; v && idx_q == IX_LEN_LO |-> d == PES_LEN[7:0]; endproperty
   a_len: assert property (p_len) else $error("bad length");
   property p_ext; v && idx_q == IX_FLAGS2 |-> d[0]; endproperty
   a_ext: assert property (p_ext) else $error("no extension flag");
   property p_did; v && idx_q == IX_DATA_ID |-> d == SYNC_DATA_ID; endproperty
   a_did: assert property (p_did) else $error("bad data id");
   property p_rflag; v && idx_q == IX_DP_FLAGS |-> d[6] == rate_q; endproperty
   a_rflag: assert property (p_rflag) else $error("bad rate flag");
   property p_hlen;
      v && idx_q == IX_DP_FLAGS |-> d[3:0] == PRIV_LEN + (rate_q ? 4'h4 : 4'h0);
   endproperty
   a_hlen: assert property (p_hlen) else $error("bad header length");
endmodule
bind sync_serial_pes_framer framer_assertions #(.PRIV_LEN(PRIV_LEN)) chk (
   .ref_clk(ref_clk),
   .rst(rst),
   .rate_cfg(rate_cfg),
   .ts_q(ts_q)
);
`default_nettype wire

// >>> tb/serial_source.sv
// Synchronous serial source sending a byte counter, MSB first.
`timescale 1ns/10ps
`default_nettype none
module serial_source (
   input wire logic rst,
   output logic ser_clk,
   output logic ser_data
);
   logic [31:0] n_q = 32'h0000_0000;
   logic [31:0] p;
   logic [7:0] b;
   initial begin
      ser_clk = 1'b0;
      #7;
      forever #24 ser_clk = ~ser_clk;
   end
   // A line clock runs free, so the stream is aligned to reset release.
   always @(posedge ser_clk) begin
      n_q <= #1 rst ? 32'h0000_0000 : n_q + 32'h0000_0001;
   end
   assign p = n_q - 32'h0000_0002;
   assign b = p[10:3];
   assign ser_data = b[~p[2:0]];
endmodule
`default_nettype wire

// >>> tb/sync_serial_pes_framer_bench.sv
// Self-checking bench for the serial stream PES framer.
`timescale 1ns/10ps
`default_nettype none
module sync_serial_pes_framer_bench;
   import pes_framer_pkg::*;
   localparam logic [3:0] PL = 4'h2;
   logic ref_clk, rst, ser_clk, ser_data, ren;
   rate_cfg_t rate_cfg;
   ts_beat_t ts_q;
   int num_errors = 0;
   int n_checks = 0;
   logic [7:0] pkt [188];
   logic [7:0] exp_pay = 8'h00;
   logic [3:0] cc = 4'h0;
   logic [7:0] rows [15][2] = '{'{8'h00, SYNC_BYTE},
      '{8'h01, {TS_HDR_TOP, 5'h01}}, '{8'h02, 8'h00}, '{8'h04, PFX_ZERO},
      '{8'h05, PFX_ZERO}, '{8'h06, PFX_ONE}, '{8'h07, PRIVATE_STREAM_ID},
      '{8'h08, PES_LEN[15:8]}, '{8'h09, PES_LEN[7:0]}, '{8'h0A, PES_FLAGS1},
      '{8'h0B, PES_FLAGS2_EXT}, '{8'h0C, PES_HDR_DATA_LEN},
      '{8'h0D, PES_EXT_BYTE}, '{8'h0E, SYNC_DATA_ID}, '{8'h0F, 8'h00}};
   sync_serial_pes_framer #(.PRIV_LEN(PL)) dut (.ref_clk(ref_clk), .rst(rst),
      .ser_clk(ser_clk), .ser_data(ser_data), .rate_cfg(rate_cfg), .ts_q(ts_q));
   serial_source src (.rst(rst), .ser_clk(ser_clk), .ser_data(ser_data));
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // The next rate setting is applied mid packet, far from byte 0.
   task automatic get_pkt(input logic nxt);
      int i = 0;
      int t = 0;
      while (i < 188 && t < 4000) begin
         @(posedge ref_clk);
         #1;
         t++;
         if (ts_q.valid === 1'b1) begin
            check("start", ts_q.start, i == 0);
            pkt[i] = ts_q.data;
            i++;
            if (i == 100) rate_cfg.rate_en = nxt;
         end
      end
      check("beats", i, 188);
   endtask
   task automatic verify();
      int k;
      int o = ren ? 21 : 17;
      logic [3:0] h = PL + (ren ? 4'h4 : 4'h0);
      foreach (rows[r]) check("hdr", pkt[rows[r][0]], rows[r][1]);
      check("cc", pkt[IX_CC], {TS_AFC_PAYLOAD, cc});
      check("dpflags", pkt[IX_DP_FLAGS], {1'b0, ren, 2'h3, h});
      if (ren) check("rate", {pkt[17], pkt[18], pkt[19], pkt[20]}, {rate_cfg.rate, RATE_RESERVED});
      for (k = 0; k < PL; k++) check("priv", pkt[o + k], 8'hFF);
      for (k = 17 + h; k < 188; k++) begin
         check("pay", pkt[k], exp_pay);
         exp_pay++;
      end
      cc++;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial begin
      #(25 * 80000);
      num_errors++;
      give_verdict();
   end
   initial begin
      rst = 1'b1;
      ren = 1'b0;
      rate_cfg = '{1'b0, 28'h123_4567};
      repeat (10) begin
         @(posedge ref_clk);
         #1;
         check("reset", ts_q, 10'h000);
      end
      rst = 1'b0;
      // Seventeen packets wrap the continuity counter and swap the rate field.
      for (int j = 0; j < 17; j++) begin
         get_pkt(~j[0]);
         verify();
         ren = ~j[0];
      end
      repeat (50) @(posedge ref_clk);
      #1;
      rst = 1'b1;
      repeat (10) begin
         @(posedge ref_clk);
         #1;
         check("reset", ts_q, 10'h000);
      end
      rst = 1'b0;
      cc = 4'h0;
      exp_pay = 8'h00;
      ren = rate_cfg.rate_en;
      get_pkt(ren);
      verify();
      give_verdict();
   end
endmodule
`default_nettype wire
